//--- design/bus_serial_port_board.sv
// Purpose: One asynchronous serial port on an 8-bit host I/O bus
// Assumes: Host strobes are synchronous to clk; line pins are not
// Notes: Instantiate twice for the dual variant
`timescale 1ns/100ps
`include "serial_port_regs.svh"

module serial_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic push, pop;
    always_comb begin
        in_ready = (cnt != (AW+1)'(DEPTH));
        out_valid = (cnt != '0);
        out_data = mem[rp];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wp = push ? ((wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1) : wp;
        next_rp = pop ? ((rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1) : rp;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
endmodule // serial_fifo

module bus_serial_port_board
    import serial_port_pkg::*;
#(
    parameter int BIT_CYC_37_5 = `BIT_NS_37_5 / `CLK_NS,
    parameter int BIT_CYC_75 = `BIT_NS_75 / `CLK_NS,
    parameter int BIT_CYC_110 = `BIT_NS_110 / `CLK_NS,
    parameter int BIT_CYC_150 = `BIT_NS_150 / `CLK_NS,
    parameter int BIT_CYC_300 = `BIT_NS_300 / `CLK_NS,
    parameter int BIT_CYC_600 = `BIT_NS_600 / `CLK_NS,
    parameter int BIT_CYC_1200 = `BIT_NS_1200 / `CLK_NS,
    parameter int BIT_CYC_1800 = `BIT_NS_1800 / `CLK_NS,
    parameter int BIT_CYC_2400 = `BIT_NS_2400 / `CLK_NS,
    parameter int BIT_CYC_4800 = `BIT_NS_4800 / `CLK_NS,
    parameter int BIT_CYC_9600 = `BIT_NS_9600 / `CLK_NS,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Host I/O bus
    input wire logic sel,
    input wire logic a0,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // Serial line
    output logic txd,
    input wire logic rxd,
    input wire logic dcd,
    input wire logic cts,
    output logic rts,
    // Straps and interrupt
    input wire logic [2:0] baud_jumper,
    input wire logic rx_interrupt_pad,
    input wire logic tx_interrupt_pad,
    input wire logic both_direction_interrupt_pad,
    output logic irq
);
    logic [8:0] sync1, sync2;
    logic rxd_s, dcd_s, cts_s, strap_rx, strap_tx, strap_both;
    logic [2:0] jump_s;
    logic [7:0] ctrl, next_ctrl, next_rdata;
    logic [23:0] bit_cyc;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [7:0] fifo_out_data;
    tx_state_t tx_state, next_tx_state;
    logic [23:0] tx_cnt, next_tx_cnt;
    logic [7:0] tx_sh, next_tx_sh;
    logic [2:0] tx_bit, next_tx_bit;
    logic tx_par, next_tx_par, tx_stop2, next_tx_stop2, next_txd;
    rx_state_t rx_state, next_rx_state;
    logic [23:0] rx_cnt, next_rx_cnt;
    logic [7:0] rx_sh, next_rx_sh, rx_buf, next_rx_buf;
    logic [2:0] rx_bit, next_rx_bit;
    logic rx_par, next_rx_par, rx_perr, next_rx_perr, rx_done;
    logic rx_avail, next_rx_avail, ovr, next_ovr, ferr, next_ferr, perr, next_perr;
    logic irq_pend, rd_data, wr_data, wr_ctrl;
    logic [7:0] status;

    // Line pins and straps pass two flip-flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 9'h1ff;
            sync2 <= 9'h1ff;
        end else begin
            sync1 <= {baud_jumper, both_direction_interrupt_pad, tx_interrupt_pad,
                      rx_interrupt_pad, cts, dcd, rxd};
            sync2 <= sync1;
        end
    end
    assign {jump_s, strap_both, strap_tx, strap_rx, cts_s, dcd_s, rxd_s} = sync2;

    // Bit time from jumper or programmable divider
    always_comb begin
        unique case ({ctrl[`CTRL_PROG_HI], ctrl[`CTRL_PROG_LO]})
            2'b01: bit_cyc = 24'(BIT_CYC_600);
            2'b10: bit_cyc = 24'(BIT_CYC_75);
            2'b11: bit_cyc = 24'(BIT_CYC_37_5);
            default: begin
                unique case (jump_s)
                    3'h0: bit_cyc = 24'(BIT_CYC_110);
                    3'h1: bit_cyc = 24'(BIT_CYC_150);
                    3'h2: bit_cyc = 24'(BIT_CYC_300);
                    3'h3: bit_cyc = 24'(BIT_CYC_1200);
                    3'h4: bit_cyc = 24'(BIT_CYC_1800);
                    3'h5: bit_cyc = 24'(BIT_CYC_2400);
                    3'h6: bit_cyc = 24'(BIT_CYC_4800);
                    default: bit_cyc = 24'(BIT_CYC_9600);
                endcase
            end
        endcase
    end

    // Host decode: even address control/status, odd address data
    assign rd_data = sel && rd && (a0 == `ADDR_DATA);
    assign wr_data = sel && wr && (a0 == `ADDR_DATA);
    assign wr_ctrl = sel && wr && (a0 == `ADDR_CTRL);

    serial_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(wr_data),
        .in_ready(fifo_in_ready),
        .in_data(wdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Transmitter
    always_comb begin
        next_tx_state = tx_state;
        next_tx_cnt = (tx_cnt == '0) ? bit_cyc - 24'h1 : tx_cnt - 24'h1;
        next_tx_sh = tx_sh;
        next_tx_bit = tx_bit;
        next_tx_par = tx_par;
        next_tx_stop2 = tx_stop2;
        next_txd = txd;
        fifo_out_ready = 1'b0;
        unique case (tx_state)
            TX_IDLE: begin
                next_tx_cnt = bit_cyc - 24'h1;
                next_txd = 1'b1;
                if (fifo_out_valid) begin
                    fifo_out_ready = 1'b1;
                    next_tx_sh = fifo_out_data;
                    next_tx_par = ^{ctrl[`CTRL_DATA8] & fifo_out_data[7], fifo_out_data[6:0]}
                                  ^ ctrl[`CTRL_PAR_ODD];
                    next_tx_stop2 = ctrl[`CTRL_STOP2];
                    next_txd = 1'b0;
                    next_tx_state = TX_START;
                end
            end
            TX_START: begin
                if (tx_cnt == '0) begin
                    next_txd = tx_sh[0];
                    next_tx_bit = '0;
                    next_tx_state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_cnt == '0) begin
                    next_tx_sh = {1'b0, tx_sh[7:1]};
                    next_tx_bit = tx_bit + 3'h1;
                    next_txd = tx_sh[1];
                    if (tx_bit == (ctrl[`CTRL_DATA8] ? 3'h7 : 3'h6)) begin
                        next_txd = ctrl[`CTRL_PAR_EN] ? tx_par : 1'b1;
                        next_tx_state = ctrl[`CTRL_PAR_EN] ? TX_PAR : TX_STOP;
                    end
                end
            end
            TX_PAR: begin
                if (tx_cnt == '0) begin
                    next_txd = 1'b1;
                    next_tx_state = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tx_cnt == '0) begin
                    next_tx_stop2 = 1'b0;
                    next_tx_state = tx_stop2 ? TX_STOP : TX_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_state <= TX_IDLE;
            tx_cnt <= '0;
            tx_sh <= '0;
            tx_bit <= '0;
            tx_par <= 1'b0;
            tx_stop2 <= 1'b0;
            txd <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            tx_cnt <= next_tx_cnt;
            tx_sh <= next_tx_sh;
            tx_bit <= next_tx_bit;
            tx_par <= next_tx_par;
            tx_stop2 <= next_tx_stop2;
            txd <= next_txd;
        end
    end

    // Receiver, sampling mid-bit
    always_comb begin
        next_rx_state = rx_state;
        next_rx_cnt = (rx_cnt == '0) ? bit_cyc - 24'h1 : rx_cnt - 24'h1;
        next_rx_sh = rx_sh;
        next_rx_bit = rx_bit;
        next_rx_par = rx_par;
        next_rx_perr = rx_perr;
        rx_done = 1'b0;
        unique case (rx_state)
            RX_IDLE: begin
                next_rx_cnt = {1'b0, bit_cyc[23:1]};
                if (!rxd_s) begin
                    next_rx_state = RX_START;
                end
            end
            RX_START: begin
                if (rx_cnt == '0) begin
                    next_rx_bit = '0;
                    next_rx_par = 1'b0;
                    next_rx_perr = 1'b0;
                    next_rx_state = rxd_s ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_cnt == '0) begin
                    next_rx_sh = {rxd_s, rx_sh[7:1]};
                    next_rx_par = rx_par ^ rxd_s;
                    next_rx_bit = rx_bit + 3'h1;
                    if (rx_bit == (ctrl[`CTRL_DATA8] ? 3'h7 : 3'h6)) begin
                        next_rx_state = ctrl[`CTRL_PAR_EN] ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_cnt == '0) begin
                    next_rx_perr = (rx_par ^ rxd_s) != ctrl[`CTRL_PAR_ODD];
                    next_rx_state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_cnt == '0) begin
                    rx_done = 1'b1;
                    next_rx_state = RX_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_state <= RX_IDLE;
            rx_cnt <= '0;
            rx_sh <= '0;
            rx_bit <= '0;
            rx_par <= 1'b0;
            rx_perr <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            rx_cnt <= next_rx_cnt;
            rx_sh <= next_rx_sh;
            rx_bit <= next_rx_bit;
            rx_par <= next_rx_par;
            rx_perr <= next_rx_perr;
        end
    end

    // Host-visible registers; a new character wins over a clearing read
    always_comb begin
        next_ctrl = wr_ctrl ? wdata : ctrl;
        next_rx_avail = rd_data ? 1'b0 : rx_avail;
        next_ovr = rd_data ? 1'b0 : ovr;
        next_ferr = rd_data ? 1'b0 : ferr;
        next_perr = rd_data ? 1'b0 : perr;
        next_rx_buf = rx_buf;
        if (rx_done) begin
            next_rx_avail = 1'b1;
            next_ovr = rx_avail && !rd_data;
            next_ferr = !rxd_s;
            next_perr = rx_perr;
            next_rx_buf = ctrl[`CTRL_DATA8] ? rx_sh : {1'b0, rx_sh[7:1]};
        end
        irq_pend = (ctrl[`CTRL_RX_IE] && rx_avail && (strap_rx || strap_both))
                 || (ctrl[`CTRL_TX_IE] && !fifo_out_valid && (strap_tx || strap_both));
        status = {!fifo_in_ready, irq_pend, cts_s, dcd_s, perr, ovr, ferr, !rx_avail};
        next_rdata = rdata;
        if (sel && rd) begin
            next_rdata = a0 ? rx_buf : status;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= `CTRL_RESET;
            rx_avail <= 1'b0;
            ovr <= 1'b0;
            ferr <= 1'b0;
            perr <= 1'b0;
            rx_buf <= '0;
            rdata <= `RDATA_RESET;
            irq <= 1'b0;
            rts <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            rx_avail <= next_rx_avail;
            ovr <= next_ovr;
            ferr <= next_ferr;
            perr <= next_perr;
            rx_buf <= next_rx_buf;
            rdata <= next_rdata;
            irq <= irq_pend;
            rts <= 1'b1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_RX_CLEAR: assert property (rd_data && !rx_done |=> !rx_avail)
        else $error("data read did not clear receive flag");
    AST_D0: assert property (sel && rd && !a0 |=> rdata[0] == !$past(rx_avail))
        else $error("status D0 wrong");
    AST_IE: assert property (wr_ctrl |=> ctrl[1:0] == $past(wdata[1:0]))
        else $error("interrupt enables not loaded");
    AST_LOAD: assert property (tx_state == TX_IDLE && fifo_out_valid |=> tx_state == TX_START
        && !txd)
        else $error("transmitter did not start");
    AST_D7: assert property (sel && rd && !a0 |=> rdata[7] == !$past(fifo_in_ready))
        else $error("status D7 wrong");
    AST_IRQ: assert property (ctrl[0] && rx_avail && strap_both |=> irq)
        else $error("receive interrupt missing");
    AST_STOP: assert property (tx_state == TX_STOP |-> txd)
        else $error("stop bit not high");
    AST_PAR: assert property (tx_state == TX_PAR |-> ctrl[`CTRL_PAR_EN])
        else $error("parity sent while disabled");
    AST_OVR: assert property (rx_done && rx_avail && !rd_data |=> ovr && rx_avail)
        else $error("overrun not flagged");
endmodule // bus_serial_port_board

//--- design/serial_port_regs.svh
// Purpose: Address, field, reset and timing constants of the serial port
// Assumes: One 100 MHz clock
// Notes: Bit times in ns, cycle counts derived in the top module
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define ADDR_CTRL 1'b0
`define ADDR_DATA 1'b1
`define CTRL_RX_IE 0
`define CTRL_TX_IE 1
`define CTRL_DATA8 2
`define CTRL_PAR_EN 3
`define CTRL_PAR_ODD 4
`define CTRL_STOP2 5
`define CTRL_PROG_LO 6
`define CTRL_PROG_HI 7
`define CTRL_RESET 8'h00
`define RDATA_RESET 8'hff
`define CLK_NS 10
`define BIT_NS_37_5 26666667
`define BIT_NS_75 13333333
`define BIT_NS_110 9090909
`define BIT_NS_150 6666667
`define BIT_NS_300 3333333
`define BIT_NS_600 1666667
`define BIT_NS_1200 833333
`define BIT_NS_1800 555556
`define BIT_NS_2400 416667
`define BIT_NS_4800 208333
`define BIT_NS_9600 104167
`endif

//--- design/serial_port_pkg.sv
// Purpose: Types shared by the serial port design
// Assumes: Nothing
// Notes: One-hot state codes
package serial_port_pkg;
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
    } tx_state_t;
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
    } rx_state_t;
endpackage

//--- dv/serial_terminal.sv
// Purpose: Serial terminal on the far side of the line
// Assumes: Bit time and frame format are set by the bench
// Notes: Decoded characters queue as {frame ok, data}
`timescale 1ns/100ps
module serial_terminal (
    // Clock
    input wire logic clk,
    // Line
    input wire logic txd,
    output logic rxd,
    // Frame format
    input wire logic [31:0] bit_cyc,
    input wire logic data8,
    input wire logic par_en,
    input wire logic par_odd,
    input wire logic stop2
);
    logic [8:0] got_q[$];
    logic [7:0] sh;
    logic ok;
    initial rxd = 1'b1;
    task automatic put(input logic b);
        rxd = b;
        repeat (bit_cyc) @(negedge clk);
    endtask
    // Short low stop keeps the receiver from seeing a fresh start
    task automatic send(input logic [7:0] v, input logic bad_par, input logic bad_stop);
        @(negedge clk);
        put(1'b0);
        for (int i = 0; i < (data8 ? 8 : 7); i++)
            put(v[i]);
        if (par_en)
            put(^(data8 ? v : {1'b0, v[6:0]}) ^ par_odd ^ bad_par);
        if (bad_stop) begin
            rxd = 1'b0;
            repeat (bit_cyc * 3 / 4) @(negedge clk);
        end
        put(1'b1);
        if (stop2)
            put(1'b1);
        put(1'b1);
    endtask
    always begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(negedge clk);
        ok = !txd;
        sh = 8'h00;
        for (int i = 0; i < (data8 ? 8 : 7); i++) begin
            repeat (bit_cyc) @(negedge clk);
            sh[i] = txd;
        end
        if (par_en) begin
            repeat (bit_cyc) @(negedge clk);
            ok = ok & (txd == (^sh ^ par_odd));
        end
        repeat (bit_cyc) @(negedge clk);
        ok = ok & txd;
        if (stop2) begin
            repeat (bit_cyc) @(negedge clk);
            ok = ok & txd;
        end
        got_q.push_back({ok, sh});
    end
endmodule // serial_terminal

//--- dv/bus_serial_port_board_tb.sv
// Purpose: Self-checking bench for the serial port board
// Assumes: Bit times shortened to 16..36 cycles by parameter
// Notes: Terminal model decodes txd and drives rxd
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected t=%0t got=%0h exp=%0h", $time, g, e); end end
module bus_serial_port_board_tb;
    logic clk = 1'b0, nrst = 1'b0, sel = 1'b0, a0 = 1'b0, rd = 1'b0, wr = 1'b0;
    logic txd, rxd, dcd, cts, rts, irq;
    logic rx_pad = 1'b1, tx_pad = 1'b0, both_pad = 1'b0;
    logic data8 = 1'b1, par_en = 1'b0, par_odd = 1'b0, stop2 = 1'b0;
    logic [7:0] wdata = 8'h00, rdata, st, d;
    logic [2:0] baud_jumper = 3'h0;
    logic [31:0] bit_cyc = 32'h10;
    logic [8:0] exp_q[$];
    logic [7:0] fmts[10] = '{8'h00, 8'h20, 8'h08, 8'h28, 8'h18, 8'h38, 8'h04, 8'h24,
        8'h0c, 8'h1c};
    // Shortened bit times, two cycles apart in rate-table order
    localparam int CYC0 = 16;
    int err_total = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    bus_serial_port_board #(.BIT_CYC_110(CYC0), .BIT_CYC_150(CYC0 + 2),
        .BIT_CYC_300(CYC0 + 4), .BIT_CYC_1200(CYC0 + 6), .BIT_CYC_1800(CYC0 + 8),
        .BIT_CYC_2400(CYC0 + 10), .BIT_CYC_4800(CYC0 + 12), .BIT_CYC_9600(CYC0 + 14),
        .BIT_CYC_600(CYC0 + 16), .BIT_CYC_75(CYC0 + 18), .BIT_CYC_37_5(CYC0 + 20)) dut (
        .clk(clk), .nrst(nrst), .sel(sel), .a0(a0), .rd(rd), .wr(wr), .wdata(wdata),
        .rdata(rdata), .txd(txd), .rxd(rxd), .dcd(dcd), .cts(cts), .rts(rts),
        .baud_jumper(baud_jumper), .rx_interrupt_pad(rx_pad), .tx_interrupt_pad(tx_pad),
        .both_direction_interrupt_pad(both_pad), .irq(irq));
    serial_terminal term (.clk(clk), .txd(txd), .rxd(rxd), .bit_cyc(bit_cyc),
        .data8(data8), .par_en(par_en), .par_odd(par_odd), .stop2(stop2));
    task automatic tally_and_finish;
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic bus_wr(input logic a, input logic [7:0] v);
        @(negedge clk);
        sel = 1'b1;
        a0 = a;
        wr = 1'b1;
        wdata = v;
        @(negedge clk);
        sel = 1'b0;
        wr = 1'b0;
    endtask
    task automatic bus_rd(input logic a, output logic [7:0] q);
        @(negedge clk);
        sel = 1'b1;
        a0 = a;
        rd = 1'b1;
        @(negedge clk);
        sel = 1'b0;
        rd = 1'b0;
        q = rdata;
    endtask
    task automatic rd_stat;
        bus_rd(1'b0, st);
        `CHK(st[5:4], {cts, dcd})
    endtask
    task automatic set_fmt(input logic [7:0] c);
        bus_wr(1'b0, c);
        data8 = c[2];
        par_en = c[3];
        par_odd = c[4];
        stop2 = c[5];
    endtask
    // Wait for all expected characters at the terminal, then compare
    task automatic drain;
        logic [8:0] g;
        int k;
        k = 0;
        while (term.got_q.size() < exp_q.size() && k < 5000) begin
            @(negedge clk);
            k++;
        end
        if (k == 5000) begin
            err_total++;
            tally_and_finish;
        end
        while (exp_q.size() > 0) begin
            g = term.got_q.pop_front();
            `CHK(g, exp_q[0])
            void'(exp_q.pop_front());
        end
    endtask
    // Receive one character, check flags, data and the cleared state
    task automatic rx_chk(input logic [7:0] v, input logic bp, input logic bs);
        term.send(v, bp, bs);
        rd_stat;
        `CHK(st[3:0], {bp & par_en, 1'b0, bs, 1'b0})
        bus_rd(1'b1, d);
        `CHK(d, data8 ? v : {1'b0, v[6:0]})
        rd_stat;
        `CHK(st[3:0], 4'h1)
    endtask
    initial begin
        void'($urandom(55));
        dcd = 1'($urandom);
        cts = 1'($urandom);
        repeat (4) @(negedge clk);
        `CHK({rts, txd, irq, rdata}, 11'h2ff)
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(rts, 1'b1)
        rd_stat;
        `CHK({st[7:6], st[3:0]}, 6'h01)
        for (int k = 0; k < 11; k++) begin
            baud_jumper = (k < 8) ? 3'(k) : 3'h0;
            bit_cyc = 32'(CYC0 + 2 * k);
            dcd = 1'($urandom);
            cts = 1'($urandom);
            set_fmt((k < 8) ? 8'h04 : {2'(k - 7), 6'h04});
            d = 8'($urandom);
            exp_q.push_back({1'b1, d});
            bus_wr(1'b1, d);
            drain;
            rd_stat;
        end
        bit_cyc = 32'(CYC0);
        set_fmt(8'h24);
        for (int i = 0; i < 10; i++) begin
            d = 8'($urandom);
            if (i < 9)
                exp_q.push_back({1'b1, d});
            bus_wr(1'b1, d);
        end
        rd_stat;
        `CHK(st[7], 1'b1)
        drain;
        repeat (400) @(negedge clk);
        `CHK(term.got_q.size(), 0)
        rd_stat;
        `CHK(st[7], 1'b0)
        foreach (fmts[f]) begin
            set_fmt(fmts[f]);
            d = 8'($urandom);
            exp_q.push_back({1'b1, data8 ? d : {1'b0, d[6:0]}});
            bus_wr(1'b1, d);
            drain;
            rx_chk(8'($urandom), 1'b0, 1'b0);
            rx_chk(8'($urandom), par_en, 1'b0);
        end
        set_fmt(8'h04);
        rx_chk(8'($urandom), 1'b0, 1'b1);
        term.send(8'h5a, 1'b0, 1'b0);
        term.send(8'ha5, 1'b0, 1'b0);
        rd_stat;
        `CHK(st[2:0], 3'h4)
        bus_rd(1'b1, d);
        `CHK(d, 8'ha5)
        rd_stat;
        `CHK(st[2:0], 3'h1)
        set_fmt(8'h05);
        term.send(8'h3c, 1'b0, 1'b0);
        `CHK(irq, 1'b1)
        bus_rd(1'b1, d);
        `CHK(d, 8'h3c)
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
        set_fmt(8'h04);
        term.send(8'hc3, 1'b0, 1'b0);
        `CHK(irq, 1'b0)
        bus_rd(1'b1, d);
        rx_pad = 1'b0;
        set_fmt(8'h05);
        term.send(8'h69, 1'b0, 1'b0);
        `CHK(irq, 1'b0)
        both_pad = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(irq, 1'b1)
        bus_rd(1'b1, d);
        `CHK(d, 8'h69)
        both_pad = 1'b0;
        rx_pad = 1'b1;
        set_fmt(8'h06);
        repeat (4) @(negedge clk);
        `CHK(irq, 1'b0)
        tx_pad = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(irq, 1'b1)
        tx_pad = 1'b0;
        both_pad = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(irq, 1'b1)
        set_fmt(8'h04);
        repeat (3) @(negedge clk);
        `CHK(irq, 1'b0)
        tally_and_finish;
    end
endmodule // bus_serial_port_board_tb
